// ### rtl/aosr_pair_buffer.sv
// small valid/ready buffer between the sensing core and the output registers
// assumes a power-of-two depth; ready toward the source is a flop
`timescale 1ns/1ps
module aosr_pair_buffer #(
	parameter int W = 18,
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// filling side and draining side
	aosr_stream_if.snk wr,
	aosr_stream_if.src rd
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
		begin : g_bad_depth
			$error("buffer depth must be a power of two of at least 2");
		end
	endgenerate

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic in_rdy_r;

	wire push = wr.valid & in_rdy_r;
	wire pop = rd.valid & rd.ready;
	wire [AW:0] cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

	assign wr.ready = in_rdy_r;
	assign rd.valid = (cnt_r != '0);
	assign rd.data = mem[rp_r];

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			in_rdy_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			in_rdy_r <= (cnt_nxt != FULL);
			if (push)
				wp_r <= wp_r + 1'b1;
			if (pop)
				rp_r <= rp_r + 1'b1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (push)
			mem[wp_r] <= wr.data;
	end
endmodule

// ### rtl/aosr_pkg.sv
// constants, field positions and types of the acceleration readout block
// assumes a 50 MHz system clock and a 6-bit address space of 8-bit registers reached over the serial port
package aosr_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int BOOT_MS = 5;
	localparam int BOOT_CYCLES = BOOT_MS * (CLK_HZ / 1000);

	localparam logic [5:0] ADDR_CW_FIRST = 6'h20;
	localparam logic [5:0] ADDR_CW_LAST = 6'h25;
	localparam logic [5:0] ADDR_REFERENCE = 6'h26;
	localparam logic [5:0] ADDR_SAMPLE_FLAGS = 6'h27;
	localparam logic [5:0] ADDR_X_LOW = 6'h28;
	localparam logic [5:0] ADDR_X_HIGH = 6'h29;
	localparam logic [5:0] ADDR_Y_HIGH = 6'h2B;
	localparam logic [5:0] ADDR_Z_HIGH = 6'h2D;

	localparam int NUM_CW = 6;
	localparam int CW_ONE = 0;
	localparam int CW_THREE = 2;
	localparam int CW_FOUR = 3;
	localparam int CW_SIX = 5;

	localparam int ONE_COARSE_BIT = 3;
	localparam int ONE_RATE_LSB = 4;
	localparam int THREE_ROUTE_BIT = 4;
	localparam int FOUR_FINE_BIT = 3;
	localparam int FOUR_SWAP_BIT = 6;
	localparam int FOUR_HOLD_BIT = 7;
	localparam int SIX_POL_BIT = 1;

	localparam int CMD_READ_BIT = 7;
	localparam int CMD_INC_BIT = 6;

	localparam logic [7:0] CW_RESET = 8'h00;
	localparam logic [7:0] REF_RESET = 8'h00;

	localparam logic [2:0] SETTLE_COARSE = 3'h1;
	localparam logic [2:0] SETTLE_FINE = 3'h7;

	localparam logic [15:0] MASK_8 = 16'hFF00;
	localparam logic [15:0] MASK_10 = 16'hFFC0;
	localparam logic [15:0] MASK_12 = 16'hFFF0;

	localparam int NUM_AXES = 3;
	localparam logic [1:0] AXIS_Z = 2'h2;
	localparam int WORD_W = 16;
	localparam int SAMPLE_W = WORD_W + 2;
	localparam int BUF_DEPTH = 2;

	// encoding is {coarse_power_select, fine_resolution_select}
	typedef enum logic [1:0] {
		RES_10 = 2'b00,
		RES_12 = 2'b01,
		RES_8 = 2'b10,
		RES_BAD = 2'b11
	} aosr_res_t;

	typedef enum logic [0:0] {
		PH_CMD = 1'b0,
		PH_DATA = 1'b1
	} aosr_phase_t;
endpackage

// ### rtl/aosr_readout.sv
// acceleration output registers, sample flags, ready pin and serial register port
// assumes samples arrive on mclk from the sensing core; the serial port is asynchronous
`timescale 1ns/1ps
module aosr_readout
	import aosr_pkg::*;
#(
	parameter int BOOT_LEN = aosr_pkg::BOOT_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// serial register port
	input wire logic spi_sck,
	input wire logic spi_csn,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	// sample stream from the sensing core
	input wire logic sample_valid,
	input wire logic [1:0] sample_axis,
	input wire logic [aosr_pkg::WORD_W-1:0] sample_word,
	output logic sample_ready,
	// event pins
	output logic first_event_pin,
	output logic second_event_pin
);
	import aosr_pkg::*;

	generate
		if (BOOT_LEN < 1)
		begin : g_bad_boot
			$error("boot length must be at least one cycle");
		end
	endgenerate

	function automatic logic [5:0] pair_addr(input int axis, input logic hi);
		pair_addr = ADDR_X_LOW + 6'(2 * axis) + 6'(hi);
	endfunction

	// pin synchronisers
	logic [2:0] sck_s;
	logic [1:0] csn_s;
	logic [1:0] mosi_s;

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			sck_s <= 3'h7;
			csn_s <= 2'h3;
			mosi_s <= 2'h0;
		end
		else
		begin
			sck_s <= {sck_s[1:0], spi_sck};
			csn_s <= {csn_s[0], spi_csn};
			mosi_s <= {mosi_s[0], spi_mosi};
		end
	end

	wire cs = ~csn_s[1];
	wire sck_rise = sck_s[1] & ~sck_s[2];
	wire sck_fall = ~sck_s[1] & sck_s[2];

	// serial framing: command byte then data bytes, msb first
	aosr_phase_t phase_r;
	logic [2:0] bit_r;
	logic [6:0] sh_r;
	logic rd_r;
	logic inc_r;
	logic [5:0] addr_r;
	logic [7:0] tx_r;
	logic miso_r;
	logic oe_r;

	wire [7:0] byte_in = {sh_r, mosi_s[1]};
	wire byte_done = cs & sck_rise & (bit_r == 3'h7);
	wire cmd_done = byte_done & (phase_r == PH_CMD);
	wire data_done = byte_done & (phase_r == PH_DATA);
	wire [5:0] next_addr = inc_r ? addr_r + 6'h01 : addr_r;
	// a byte counts as read only when its first bit leaves, so a cut burst has no side effect
	wire rd_fetch = cs & sck_fall & (phase_r == PH_DATA) & rd_r & (bit_r == 3'h0);
	wire [5:0] rd_addr = addr_r;
	wire wr_strobe = data_done & ~rd_r;
	wire [7:0] rd_data;

	always_ff @(posedge mclk)
	begin
		if (!rstn || !cs)
		begin
			phase_r <= PH_CMD;
			bit_r <= 3'h0;
			sh_r <= 7'h00;
			rd_r <= 1'b0;
			inc_r <= 1'b0;
			addr_r <= 6'h00;
		end
		else if (sck_rise)
		begin
			bit_r <= bit_r + 3'h1;
			sh_r <= byte_in[6:0];
			if (cmd_done)
			begin
				phase_r <= PH_DATA;
				rd_r <= byte_in[CMD_READ_BIT];
				inc_r <= byte_in[CMD_INC_BIT];
				addr_r <= byte_in[5:0];
			end
			else if (data_done)
				addr_r <= next_addr;
		end
	end

	// miso changes on falling sck, host samples on rising
	always_ff @(posedge mclk)
	begin
		if (!rstn || !cs)
			tx_r <= 8'h00;
		else if (rd_fetch)
			tx_r <= {rd_data[6:0], 1'b0};
		else if (sck_fall)
			tx_r <= {tx_r[6:0], 1'b0};
	end

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			miso_r <= 1'b0;
			oe_r <= 1'b0;
		end
		else
		begin
			oe_r <= cs & (phase_r == PH_DATA) & rd_r;
			if (!cs)
				miso_r <= 1'b0;
			else if (sck_fall)
				miso_r <= rd_fetch ? rd_data[7] : tx_r[7];
		end
	end

	// control words and reference
	logic [7:0] cw_r [NUM_CW];
	logic [7:0] ref_r;
	logic boot_r;
	logic [31:0] boot_cnt_r;

	wire boot_end = boot_r & (boot_cnt_r == 32'(BOOT_LEN - 1));
	wire cw_hit = wr_strobe & (addr_r >= ADDR_CW_FIRST) & (addr_r <= ADDR_CW_LAST);
	wire [2:0] cw_idx = addr_r[2:0];

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			boot_r <= 1'b1;
			boot_cnt_r <= 32'h0;
		end
		else if (boot_r)
		begin
			boot_cnt_r <= boot_cnt_r + 32'h1;
			boot_r <= ~boot_end;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < NUM_CW; i++)
				cw_r[i] <= CW_RESET;
			ref_r <= REF_RESET;
		end
		else
		begin
			if (cw_hit)
				cw_r[cw_idx] <= byte_in;
			if (wr_strobe && addr_r == ADDR_REFERENCE)
				ref_r <= byte_in;
			// boot finishes in power-down whatever was written meanwhile
			if (boot_end)
				cw_r[CW_ONE][7:ONE_RATE_LSB] <= 4'h0;
		end
	end

	wire [2:0] axis_en = cw_r[CW_ONE][2:0];
	wire [3:0] rate = cw_r[CW_ONE][7:ONE_RATE_LSB];
	wire route = cw_r[CW_THREE][THREE_ROUTE_BIT];
	wire hold = cw_r[CW_FOUR][FOUR_HOLD_BIT];
	wire pol = cw_r[CW_SIX][SIX_POL_BIT];
	// the first event latch bit is stored but deliberately not decoded here
	wire [1:0] res_bits = {cw_r[CW_ONE][ONE_COARSE_BIT], cw_r[CW_FOUR][FOUR_FINE_BIT]};
	aosr_res_t res;
	assign res = aosr_res_t'(res_bits);
	wire swap_on = cw_r[CW_FOUR][FOUR_SWAP_BIT] & (res == RES_12);
	wire [15:0] res_mask = (res == RES_8) ? MASK_8 : (res == RES_10) ? MASK_10 : MASK_12;

	// sample path through the buffer
	aosr_stream_if #(.W(SAMPLE_W)) in_if ();
	aosr_stream_if #(.W(SAMPLE_W)) out_if ();

	assign in_if.valid = sample_valid;
	assign in_if.data = {sample_axis, sample_word};
	assign sample_ready = in_if.ready;

	aosr_pair_buffer #(.W(SAMPLE_W), .DEPTH(BUF_DEPTH)) u_buffer (
		.mclk(mclk),
		.rstn(rstn),
		.wr(in_if),
		.rd(out_if)
	);

	logic [2:0] lo_seen_r;
	logic [2:0] hi_seen_r;
	logic [2:0] settle_r;
	aosr_res_t res_prev_r;

	wire [1:0] head_axis = out_if.data[SAMPLE_W-1:WORD_W];
	wire [15:0] head_word = out_if.data[WORD_W-1:0];
	wire [3:0] lock4 = {1'b0, lo_seen_r | hi_seen_r};
	// a held pair stalls the whole queue; the source sees it as back-pressure
	assign out_if.ready = ~(hold & lock4[head_axis]);
	wire take = out_if.valid & out_if.ready;
	wire running = ~boot_r & (rate != 4'h0) & (res != RES_BAD);
	wire accept = take & running & (settle_r == 3'h0);

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			settle_r <= 3'h0;
			res_prev_r <= RES_10;
		end
		else
		begin
			res_prev_r <= res;
			if (res != res_prev_r)
				settle_r <= (res == RES_12) ? SETTLE_FINE : SETTLE_COARSE;
			else if (take && running && head_axis == AXIS_Z && settle_r != 3'h0)
				settle_r <= settle_r - 3'h1;
		end
	end

	// per-axis flags, output words and pair hold
	logic [2:0] new_r;
	logic [2:0] ov_r;
	logic all_r;
	logic any_r;
	logic [15:0] out_r [NUM_AXES];
	logic [2:0] wr_ax;
	logic [2:0] rd_lo;
	logic [2:0] rd_hi;
	logic [2:0] new_nxt;
	logic [2:0] ov_set;
	logic [2:0] ov_nxt;
	logic [7:0] axis_byte [2*NUM_AXES];

	genvar g;
	generate
		for (g = 0; g < NUM_AXES; g++)
		begin : g_axis
			wire lo_nxt = hold & (lo_seen_r[g] | rd_lo[g]);
			wire hi_nxt = hold & (hi_seen_r[g] | rd_hi[g]);
			assign wr_ax[g] = accept & (head_axis == 2'(g)) & axis_en[g];
			assign rd_lo[g] = rd_fetch & (rd_addr == pair_addr(g, 1'b0));
			assign rd_hi[g] = rd_fetch & (rd_addr == pair_addr(g, 1'b1));
			assign new_nxt[g] = wr_ax[g] | (new_r[g] & ~rd_hi[g]);
			assign ov_set[g] = wr_ax[g] & new_r[g] & ~rd_hi[g];
			assign ov_nxt[g] = ov_set[g] | (ov_r[g] & ~rd_hi[g]);
			assign axis_byte[2*g] = !axis_en[g] ? 8'h00 :
				swap_on ? out_r[g][15:8] : out_r[g][7:0];
			assign axis_byte[2*g+1] = !axis_en[g] ? 8'h00 :
				swap_on ? out_r[g][7:0] : out_r[g][15:8];

			always_ff @(posedge mclk)
			begin
				if (!rstn)
				begin
					lo_seen_r[g] <= 1'b0;
					hi_seen_r[g] <= 1'b0;
					out_r[g] <= 16'h0000;
				end
				else
				begin
					lo_seen_r[g] <= lo_nxt & ~hi_nxt;
					hi_seen_r[g] <= hi_nxt & ~lo_nxt;
					if (wr_ax[g])
						out_r[g] <= head_word & res_mask;
				end
			end
		end
	endgenerate

	wire all_set = ~|(axis_en & ~new_nxt) & |axis_en;
	wire all_none = ~|(axis_en & new_nxt);
	wire z_gen = accept & (head_axis == AXIS_Z);
	wire all_nxt = (z_gen & all_set) | (all_r & ~all_none);
	wire any_nxt = |ov_set | (any_r & |ov_nxt);

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			new_r <= 3'h0;
			ov_r <= 3'h0;
			all_r <= 1'b0;
			any_r <= 1'b0;
		end
		else
		begin
			new_r <= new_nxt;
			ov_r <= ov_nxt;
			all_r <= all_nxt;
			any_r <= any_nxt;
		end
	end

	// register read selection
	wire [7:0] flags_byte = {any_r, ov_r, all_r, new_r};
	wire in_cw = (rd_addr >= ADDR_CW_FIRST) & (rd_addr <= ADDR_CW_LAST);
	wire in_out = (rd_addr >= ADDR_X_LOW) & (rd_addr <= ADDR_Z_HIGH);
	wire [2:0] out_idx = rd_addr[2:0] - ADDR_X_LOW[2:0];
	assign rd_data = in_cw ? cw_r[rd_addr[2:0]] :
		(rd_addr == ADDR_REFERENCE) ? ref_r :
		(rd_addr == ADDR_SAMPLE_FLAGS) ? flags_byte :
		in_out ? axis_byte[out_idx] : 8'h00;

	// event pins; no latching applies to the ready signal
	logic first_r;
	logic second_r;

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			first_r <= 1'b0;
			second_r <= 1'b0;
		end
		else
		begin
			first_r <= (route & all_r) ^ pol;
			second_r <= pol;
		end
	end

	assign spi_miso = miso_r;
	assign spi_miso_oe = oe_r;
	assign first_event_pin = first_r;
	assign second_event_pin = second_r;
endmodule

// ### rtl/aosr_stream_if.sv
// valid/ready stream carrying one tagged sample word
// assumes both ends on the same clock
`timescale 1ns/1ps
interface aosr_stream_if #(parameter int W = 18);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ### sim/aosr_host_model.sv
// serial host in mode 3: one command byte and one or two data bytes per access
// assumes calls start just after an mclk edge; 160 ns serial clock
`timescale 1ns/1ps
module aosr_host_model (
	// serial lines
	output logic spi_sck,
	output logic spi_csn,
	output logic spi_mosi,
	input wire logic spi_miso
);
	initial
	begin
		spi_sck = 1'b1;
		spi_csn = 1'b1;
		spi_mosi = 1'b0;
	end
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input int nb,
		output logic [15:0] rd);
		logic [23:0] sh;
		sh = {cmd, wd, 8'h00};
		spi_csn = 1'b0;
		#80;
		for (int i = 0; i < 8 * nb + 8; i++)
		begin
			spi_sck = 1'b0;
			spi_mosi = sh[23];
			#80;
			spi_sck = 1'b1;
			sh = {sh[22:0], spi_miso};
			#80;
		end
		rd = sh[15:0];
		spi_csn = 1'b1;
		// released line must not look like a held bit
		spi_mosi = ~spi_mosi;
		#80;
	endtask
endmodule

// ### sim/aosr_readout_monitor.sv
// concurrent checks on the pins of the acceleration readout block
// assumes one mclk domain; bound into every aosr_readout instance
`timescale 1ns/1ps
module aosr_readout_monitor #(
	parameter int BOOT_LEN = 20
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// serial port
	input wire logic spi_sck,
	input wire logic spi_csn,
	input wire logic spi_mosi,
	input wire logic spi_miso,
	input wire logic spi_miso_oe,
	// sample stream
	input wire logic sample_valid,
	input wire logic [1:0] sample_axis,
	input wire logic [aosr_pkg::WORD_W-1:0] sample_word,
	input wire logic sample_ready,
	// event pins
	input wire logic first_event_pin,
	input wire logic second_event_pin
);
	import aosr_pkg::*;
	logic [3:0] quiet_r;
	logic [3:0] quiet_nxt;
	logic busy;
	// pins may only move shortly after a taken sample or a serial access
	assign busy = !spi_csn || (sample_valid && sample_ready);
	assign quiet_nxt = busy ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hF};
	always_ff @(posedge mclk)
	begin
		if (!rstn)
			quiet_r <= 4'h0;
		else
			quiet_r <= quiet_nxt;
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	reset_quiet_a: assert property ($rose(rstn) |-> !sample_ready && !first_event_pin
		&& !second_event_pin) else $error("outputs active right after reset");
	ready_up_a: assert property ($rose(rstn) |=> sample_ready)
		else $error("stream not ready after reset");
	miso_idle_a: assert property (!spi_miso_oe |-> !spi_miso)
		else $error("data line not low while undriven");
	oe_idle_a: assert property (spi_csn [*4] |-> !spi_miso_oe)
		else $error("data line driven while deselected");
	oe_start_a: assert property ($rose(spi_miso_oe) |-> !spi_csn)
		else $error("drive started without select");
	miso_hold_a: assert property (($stable(spi_sck) && $stable(spi_csn)) [*6]
		|-> $stable(spi_miso)) else $error("read bit moved without clock edge");
	ready_pin_a: assert property (quiet_r > 4'h8 |-> $stable(first_event_pin))
		else $error("ready pin moved without cause");
	second_pin_a: assert property (quiet_r > 4'h8 |-> $stable(second_event_pin))
		else $error("second pin moved without cause");
	cover property (sample_valid && !sample_ready);
	cover property ($rose(first_event_pin));
	cover property ($rose(spi_miso_oe));
endmodule
bind aosr_readout aosr_readout_monitor #(.BOOT_LEN(BOOT_LEN)) u_mon (.mclk, .rstn,
	.spi_sck, .spi_csn, .spi_mosi, .spi_miso, .spi_miso_oe, .sample_valid,
	.sample_axis, .sample_word, .sample_ready, .first_event_pin, .second_event_pin);

// ### sim/testbench.sv
// self-checking bench for the acceleration readout block
// assumes the host model owns the serial lines; mclk 50 MHz
`timescale 1ns/1ps
module testbench;
	import aosr_pkg::*;
	logic mclk, rstn, spi_sck, spi_csn, spi_mosi, spi_miso, spi_miso_oe;
	logic sample_valid, sample_ready, first_event_pin, second_event_pin;
	logic [1:0] sample_axis;
	logic [15:0] sample_word;
	logic [7:0] d;
	int errors;
	int total_checks;
	// short boot keeps the run brief
	aosr_readout #(.BOOT_LEN(20)) u_dut (.mclk, .rstn, .spi_sck, .spi_csn, .spi_mosi,
		.spi_miso, .spi_miso_oe, .sample_valid, .sample_axis, .sample_word,
		.sample_ready, .first_event_pin, .second_event_pin);
	aosr_host_model u_host (.spi_sck, .spi_csn, .spi_mosi, .spi_miso);
	always #10 mclk = ~mclk;
	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e)
		begin
			errors++;
			$display("FAIL %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic pins(input logic e1, input logic e2);
		chk("pin1", {7'h00, e1}, {7'h00, first_event_pin});
		chk("pin2", {7'h00, e2}, {7'h00, second_event_pin});
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] v);
		logic [15:0] r;
		u_host.xfer({2'b00, a}, v, 1, r);
	endtask
	task automatic rd(input logic [5:0] a, output logic [7:0] v);
		logic [15:0] r;
		u_host.xfer({2'b10, a}, 8'h00, 1, r);
		v = r[7:0];
	endtask
	task automatic rchk(input string n, input logic [5:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		chk(n, e, v);
	endtask
	task automatic put(input logic [1:0] a, input logic [15:0] w);
		int n;
		@(posedge mclk);
		#1;
		sample_axis = a;
		sample_word = w;
		sample_valid = 1'b1;
		n = 0;
		while (sample_ready !== 1'b1 && n < 50)
		begin
			@(posedge mclk);
			#1;
			n++;
		end
		@(posedge mclk);
		#1;
		sample_valid = 1'b0;
		sample_word = ~w;
		if (n == 50)
		begin
			errors++;
			print_verdict();
		end
	endtask
	task automatic set3(input logic [15:0] w);
		for (int a = 0; a < NUM_AXES; a++)
			put(a[1:0], w);
		repeat (4) @(posedge mclk);
		#1;
	endtask
	task automatic clr();
		rd(ADDR_X_HIGH, d);
		rd(ADDR_Y_HIGH, d);
		rd(ADDR_Z_HIGH, d);
	endtask
	// counts sets until a complete one shows up after a mode change
	task automatic settle(input int e);
		logic [7:0] s;
		int n;
		s = 8'h00;
		n = 0;
		while (s[3] !== 1'b1 && n < 12)
		begin
			set3(16'h12F5);
			n++;
			rd(ADDR_SAMPLE_FLAGS, s);
		end
		if (e > 0)
			chk("sets", e[7:0], n[7:0]);
		clr();
	endtask
	task automatic t_reset();
		rchk("flags", ADDR_SAMPLE_FLAGS, 8'h00);
		for (int i = 0; i < NUM_CW; i++)
			rchk("cw", ADDR_CW_FIRST + i[5:0], CW_RESET);
		pins(1'b0, 1'b0);
		set3(16'h12F5);
		rchk("flags", ADDR_SAMPLE_FLAGS, 8'h00);
		rchk("unmapped", 6'h3F, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_ready();
		wr(ADDR_CW_FIRST + 6'h02, 8'h10);
		wr(ADDR_CW_FIRST + 6'h04, 8'h08);
		wr(ADDR_CW_FIRST, 8'h17);
		settle(0);
		set3(16'h12F5);
		pins(1'b1, 1'b0);
		rchk("flags", ADDR_SAMPLE_FLAGS, 8'h0F);
		rchk("xl", ADDR_X_LOW, 8'hC0);
		rchk("xh", ADDR_X_HIGH, 8'h12);
		rchk("flags", ADDR_SAMPLE_FLAGS, 8'h0E);
		clr();
		pins(1'b0, 1'b0);
		rchk("flags", ADDR_SAMPLE_FLAGS, 8'h00);
		$display("test ready done");
	endtask
	// auto-increment burst; a burst cut before the high byte must not clear that pair's flag
	task automatic t_burst();
		logic [15:0] r;
		set3(16'h12F5);
		u_host.xfer(8'hE8, 8'h00, 2, r);
		chk("xl", 8'hC0, r[15:8]);
		chk("xh", 8'h12, r[7:0]);
		u_host.xfer(8'hEC, 8'h00, 1, r);
		chk("zl", 8'hC0, r[7:0]);
		rchk("flags", ADDR_SAMPLE_FLAGS, 8'h0E);
		clr();
		$display("test burst done");
	endtask
	task automatic t_overrun();
		set3(16'h12F5);
		set3(16'h12F5);
		rchk("flags", ADDR_SAMPLE_FLAGS, 8'hFF);
		rchk("xh", ADDR_X_HIGH, 8'h12);
		rchk("flags", ADDR_SAMPLE_FLAGS, 8'hEE);
		clr();
		rchk("flags", ADDR_SAMPLE_FLAGS, 8'h00);
		$display("test overrun done");
	endtask
	task automatic t_modes();
		wr(ADDR_CW_FIRST + 6'h03, 8'h08);
		settle(8);
		wr(ADDR_CW_FIRST + 6'h03, 8'h48);
		set3(16'h12F5);
		rchk("xl", ADDR_X_LOW, 8'h12);
		rchk("xh", ADDR_X_HIGH, 8'hF0);
		clr();
		wr(ADDR_CW_FIRST + 6'h03, 8'h40);
		settle(2);
		rchk("xl", ADDR_X_LOW, 8'hC0);
		wr(ADDR_CW_FIRST, 8'h1F);
		settle(2);
		rchk("xl", ADDR_X_LOW, 8'h00);
		wr(ADDR_CW_FIRST + 6'h03, 8'h08);
		set3(16'h12F5);
		rchk("flags", ADDR_SAMPLE_FLAGS, 8'h00);
		wr(ADDR_CW_FIRST + 6'h03, 8'h00);
		settle(2);
		$display("test modes done");
	endtask
	task automatic t_misc();
		wr(ADDR_CW_FIRST + 6'h03, 8'h80);
		rd(ADDR_X_LOW, d);
		put(2'h0, 16'h34F5);
		rchk("xh", ADDR_X_HIGH, 8'h12);
		rchk("xh", ADDR_X_HIGH, 8'h34);
		rd(ADDR_X_LOW, d);
		wr(ADDR_CW_FIRST + 6'h03, 8'h00);
		clr();
		wr(ADDR_CW_FIRST, 8'h1E);
		put(2'h0, 16'h5555);
		rchk("xh", ADDR_X_HIGH, 8'h00);
		wr(ADDR_CW_FIRST + 6'h05, 8'h02);
		pins(1'b1, 1'b1);
		$display("test misc done");
	endtask
	initial
	begin
		mclk = 1'b0;
		rstn = 1'b0;
		sample_valid = 1'b0;
		sample_axis = 2'h0;
		sample_word = 16'h0000;
		errors = 0;
		total_checks = 0;
		repeat (16) @(posedge mclk);
		#1;
		rstn = 1'b1;
		repeat (30) @(posedge mclk);
		#1;
		t_reset();
		t_ready();
		t_burst();
		t_overrun();
		t_modes();
		t_misc();
		print_verdict();
	end
endmodule
